/* File: hw/sfl_pkg.sv */
// Constants, register map and state types of the SPI status flag logic.
// Assumes a 32-bit APB master and a single 40 MHz ref_clk domain.
// How it works
// - Receive-ready is set by a new character and cleared by reading receive data.
// - Transmit-ready is high after reset, low from a data write until shifter load.
// - Slave only: character starting with full receive buffer sets overrun, drops data.
// - Slave only: first clock of a character with nothing loaded sets underrun.
// - Any select going asserted sets the sticky select-asserted flag.
// - Any select going deasserted sets the sticky select-released flag.
// - Stalled bit shows the master waiting mid-transfer for data or for receive data to be read; resets to zero.
// - Master only: writing one to bit 7 ends the transfer after the current frame finishes.
// - Forced end bit stays set until select is released at transfer end.
// - A forced end still inserts the frame gap and transfer gap.
// - Master-idle is high only with empty holding register and nothing shifting.
// - Overrun, underrun and select flags clear by writing one; read-only bits ignore writes.
// - Master keeps select deasserted one SPI clock plus transfer gap between transfers.
// - With end-of-frame set the master waits the frame gap before next frame or release.
package sfl_pkg;
    localparam logic [31:0] SFL_CFG_ADDR     = 32'h4005_8000;
    localparam logic [31:0] SFL_DLY_ADDR     = 32'h4005_8004;
    localparam logic [31:0] SFL_STAT_ADDR    = 32'h4005_8008;
    localparam logic [31:0] SFL_INTEN_ADDR   = 32'h4005_800C;
    localparam logic [31:0] SFL_INTCLR_ADDR  = 32'h4005_8010;
    localparam logic [31:0] SFL_RECEIVE_DATA_REGISTER_ADDR   = 32'h4005_8014;
    localparam logic [31:0] SFL_TXCTL_ADDR   = 32'h4005_8018;
    localparam logic [31:0] SFL_TRANSMIT_DATA_REGISTER_ADDR   = 32'h4005_801C;
    localparam logic [31:0] SFL_INTSTAT_ADDR = 32'h4005_8020;

    localparam int SFL_CFG_EN_BIT     = 0;
    localparam int SFL_CFG_MASTER_BIT = 2;
    localparam int SFL_CFG_SPOL_BIT   = 8;
    localparam int SFL_DLY_FRAME_LSB  = 8;
    localparam int SFL_DLY_XFER_LSB   = 12;
    localparam int SFL_TX_EOT_BIT     = 20;
    localparam int SFL_TX_EOF_BIT     = 21;

    localparam int SFL_ST_RX_READY_FLAG  = 0;
    localparam int SFL_ST_TX_READY_FLAG  = 1;
    localparam int SFL_ST_OV     = 2;
    localparam int SFL_ST_UR     = 3;
    localparam int SFL_ST_SSA    = 4;
    localparam int SFL_ST_SSD    = 5;
    localparam int SFL_ST_STALL  = 6;
    localparam int SFL_ST_FEND   = 7;
    localparam int SFL_ST_MIDLE  = 8;

    localparam logic [31:0] SFL_STAT_RST = 32'h0000_0102;
    localparam logic [7:0]  SFL_SCK_HALF = 8'h04;
    localparam logic [4:0]  SFL_FRAME_PHASES = 5'h10;

    typedef enum logic [2:0] {
        ST_IDLE, ST_LEAD, ST_SHIFT, ST_FGAP, ST_STALL, ST_XGAP
    } sfl_state_t;

    typedef struct packed {
        sfl_state_t  st;
        logic        en;
        logic        master;
        logic        spol;
        logic [3:0]  fgap;
        logic [3:0]  xgap;
        logic [5:0]  int_en;
        logic [5:0]  int_stat;
        logic        rx_ready;
        logic        tx_ready;
        logic        ov;
        logic        ur;
        logic        select_asserted_flag;
        logic        select_released_flag;
        logic        force_end;
        logic [7:0]  rx_buf;
        logic        hold_full;
        logic [7:0]  hold;
        logic        hold_eot;
        logic        hold_eof;
        logic [7:0]  sh_tx;
        logic [7:0]  sh_rx;
        logic [4:0]  bits;
        logic        fr_eot;
        logic        fr_eof;
        logic        discard;
        logic        slv_loaded;
        logic [7:0]  tick;
        logic [5:0]  gcnt;
        logic        m_sel;
        logic        sel_prev;
        logic        sck_prev;
        logic        sck_r;
        logic        sck_oe_r;
        logic        sdo_r;
        logic        sdo_oe_r;
        logic        ssel_r;
        logic        ssel_oe_r;
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
        logic        irq;
    } sfl_regs_t;
endpackage

/* File: hw/sfl_sync.sv */
// Three-stage input synchroniser with agreement filter.
// Assumes inputs are asynchronous to ref_clk.
`timescale 1ns/10ps
module sfl_sync #(
    parameter int WIDTH = 3
) (
    input  wire logic             ref_clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] din,
    output logic      [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] s1_reg;
    logic [WIDTH-1:0] s2_reg;
    logic [WIDTH-1:0] s3_reg;
    logic [WIDTH-1:0] held_reg;

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            s1_reg   <= '0;
            s2_reg   <= '0;
            s3_reg   <= '0;
            held_reg <= '0;
        end else begin
            s1_reg   <= din;
            s2_reg   <= s1_reg;
            s3_reg   <= s2_reg;
            held_reg <= dout;
        end
    end

    // Accept a change once stages two and three agree, no extra stage
    always_comb begin
        for (int i = 0; i < WIDTH; i++) begin
            dout[i] = (s2_reg[i] == s3_reg[i]) ? s3_reg[i] : held_reg[i];
        end
    end
endmodule

/* File: hw/sfl_top.sv */
// SPI status flags, master/slave shifter and APB register file.
// Assumes APB master on ref_clk; SPI pins resolved outside from enables.
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/10ps
module sfl_top
    import sfl_pkg::*;
#(
    parameter logic [7:0] SCK_HALF = sfl_pkg::SFL_SCK_HALF
) (
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             irq,
    input  wire logic        sck_in,
    output logic             sck_out,
    output logic             sck_oe,
    input  wire logic        ssel_in,
    output logic             ssel_out,
    output logic             ssel_oe,
    input  wire logic        sdi,
    output logic             sdo,
    output logic             sdo_oe
);
    import sfl_pkg::*;

    sfl_regs_t   r;
    sfl_regs_t   n;
    logic [2:0]  pins_s;
    logic        sck_s;
    logic        ssel_s;
    logic        sdi_s;
    logic        half;
    logic        setup;
    logic        acc;
    logic        sel_in_act;
    logic        cur_sel;
    logic        slv;
    logic        srise;
    logic        sfall;
    logic        fr_end;
    logic [31:0] stat;
    logic [5:0]  ev;

    sfl_sync #(
        .WIDTH (3)
    ) u_sync (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .din     ({sck_in, ssel_in, sdi}),
        .dout    (pins_s)
    );

    assign sck_s  = pins_s[2];
    assign ssel_s = pins_s[1];
    assign sdi_s  = pins_s[0];

    always_comb begin
        n          = r;
        ev         = '0;
        fr_end     = 1'b0;
        half       = (r.tick == SCK_HALF - 8'h01);
        n.tick     = half ? 8'h00 : r.tick + 8'h01;
        setup      = psel && !penable;
        acc        = psel && penable && r.pready;
        sel_in_act = r.spol ? ssel_s : !ssel_s;
        slv        = r.en && !r.master;
        srise      = sck_s && !r.sck_prev;
        sfall      = !sck_s && r.sck_prev;
        n.sck_prev = sck_s;

        stat = '0;
        stat[SFL_ST_RX_READY_FLAG] = r.rx_ready;
        stat[SFL_ST_TX_READY_FLAG] = r.tx_ready;
        stat[SFL_ST_OV]    = r.ov;
        stat[SFL_ST_UR]    = r.ur;
        stat[SFL_ST_SSA]   = r.select_asserted_flag;
        stat[SFL_ST_SSD]   = r.select_released_flag;
        stat[SFL_ST_STALL] = (r.st == ST_STALL);
        stat[SFL_ST_FEND]  = r.force_end;
        stat[SFL_ST_MIDLE] = !r.hold_full && (r.st == ST_IDLE)
                             && !(slv && sel_in_act);

        // APB answer one cycle after setup
        n.pready  = setup;
        n.pslverr = 1'b0;
        if (setup) begin
            case (paddr)
                SFL_CFG_ADDR: begin
                    n.prdata = '0;
                    n.prdata[SFL_CFG_EN_BIT]     = r.en;
                    n.prdata[SFL_CFG_MASTER_BIT] = r.master;
                    n.prdata[SFL_CFG_SPOL_BIT]   = r.spol;
                end
                SFL_DLY_ADDR:     n.prdata = {16'h0000, r.xgap, r.fgap, 8'h00};
                SFL_STAT_ADDR:    n.prdata = stat;
                SFL_INTEN_ADDR:   n.prdata = {26'h000_0000, r.int_en};
                SFL_RECEIVE_DATA_REGISTER_ADDR:   n.prdata = {24'h00_0000, r.rx_buf};
                SFL_INTSTAT_ADDR: n.prdata = {26'h000_0000, r.int_stat};
                SFL_INTCLR_ADDR, SFL_TXCTL_ADDR, SFL_TRANSMIT_DATA_REGISTER_ADDR: n.prdata = '0;
                default: begin
                    n.prdata  = '0;
                    n.pslverr = 1'b1;
                end
            endcase
        end

        // Software side, applied before hardware sets so sets win
        if (acc && !pwrite && paddr == SFL_RECEIVE_DATA_REGISTER_ADDR) begin
            n.rx_ready = 1'b0;
        end
        if (acc && pwrite) begin
            case (paddr)
                SFL_CFG_ADDR: begin
                    n.en     = pwdata[SFL_CFG_EN_BIT];
                    n.master = pwdata[SFL_CFG_MASTER_BIT];
                    n.spol   = pwdata[SFL_CFG_SPOL_BIT];
                end
                SFL_DLY_ADDR: begin
                    n.fgap = pwdata[SFL_DLY_FRAME_LSB +: 4];
                    n.xgap = pwdata[SFL_DLY_XFER_LSB +: 4];
                end
                SFL_STAT_ADDR: begin
                    // Zero bits leave flags alone
                    if (pwdata[SFL_ST_OV])   n.ov = 1'b0;
                    if (pwdata[SFL_ST_UR])   n.ur = 1'b0;
                    if (pwdata[SFL_ST_SSA])  n.select_asserted_flag = 1'b0;
                    if (pwdata[SFL_ST_SSD])  n.select_released_flag = 1'b0;
                    if (pwdata[SFL_ST_FEND]) n.force_end = 1'b1;
                end
                SFL_INTEN_ADDR:  n.int_en = pwdata[5:0];
                SFL_INTCLR_ADDR: n.int_stat = r.int_stat & ~pwdata[5:0];
                SFL_TXCTL_ADDR, SFL_TRANSMIT_DATA_REGISTER_ADDR: begin
                    n.hold      = pwdata[7:0];
                    n.hold_full = 1'b1;
                    n.tx_ready  = 1'b0;
                    if (paddr == SFL_TXCTL_ADDR) begin
                        n.hold_eot = pwdata[SFL_TX_EOT_BIT];
                        n.hold_eof = pwdata[SFL_TX_EOF_BIT];
                    end
                end
                default: ;
            endcase
        end

        // Master engine
        case (r.st)
            ST_IDLE: begin
                n.sck_r = 1'b0;
                if (r.en && r.master && r.hold_full && !r.rx_ready) begin
                    n.m_sel = 1'b1;
                    n.gcnt  = 6'h02;
                    n.tick  = 8'h00;
                    n.st    = ST_LEAD;
                end
            end
            ST_LEAD, ST_FGAP, ST_XGAP: begin
                if (half) begin
                    n.gcnt = r.gcnt - 6'h01;
                end
                if (half && r.gcnt <= 6'h01) begin
                    if (r.st == ST_XGAP) begin
                        n.st = ST_IDLE;
                    end else if (r.st == ST_FGAP && (r.fr_eot || r.force_end)) begin
                        // Release select, then hold it off
                        n.m_sel     = 1'b0;
                        n.force_end = 1'b0;
                        n.gcnt      = {1'b0, r.xgap, 1'b0} + 6'h02;
                        n.st        = ST_XGAP;
                    end else if (r.hold_full && !r.rx_ready) begin
                        n.sh_tx     = r.hold;
                        n.fr_eot    = r.hold_eot;
                        n.fr_eof    = r.hold_eof;
                        n.hold_full = 1'b0;
                        n.tx_ready  = 1'b1;
                        n.bits      = 5'h00;
                        n.st        = ST_SHIFT;
                    end else begin
                        n.st = ST_STALL;
                    end
                end
            end
            ST_SHIFT: begin
                if (half) begin
                    n.bits  = r.bits + 5'h01;
                    n.sck_r = !r.bits[0];
                    if (!r.bits[0]) begin
                        n.sh_rx = {r.sh_rx[6:0], sdi_s};
                    end else begin
                        n.sh_tx = {r.sh_tx[6:0], 1'b0};
                    end
                    if (r.bits == SFL_FRAME_PHASES - 5'h01) begin
                        fr_end = 1'b1;
                        // Frame gap when marked or when ending
                        if (r.fr_eof || r.fr_eot || r.force_end) begin
                            n.gcnt = {1'b0, r.fgap, 1'b0};
                        end else begin
                            n.gcnt = 6'h00;
                        end
                        n.st = ST_FGAP;
                    end
                end
            end
            ST_STALL: begin
                if (r.force_end) begin
                    n.tick = 8'h00;
                    n.gcnt = {1'b0, r.fgap, 1'b0};
                    n.st   = ST_FGAP;
                end else if (r.hold_full && !r.rx_ready) begin
                    n.gcnt = 6'h00;
                    n.st   = ST_FGAP;
                end
            end
            default: n.st = ST_IDLE;
        endcase
        if (!r.en || !r.master) begin
            n.st    = ST_IDLE;
            n.m_sel = 1'b0;
            n.sck_r = 1'b0;
        end
        if (fr_end && !(r.rx_ready && !(acc && !pwrite && paddr == SFL_RECEIVE_DATA_REGISTER_ADDR))) begin
            n.rx_buf   = n.sh_rx;
            n.rx_ready = 1'b1;
        end

        // Slave engine
        if (slv && sel_in_act) begin
            if (!r.sel_prev) begin
                n.bits       = 5'h00;
                n.slv_loaded = r.hold_full;
                if (r.hold_full) begin
                    n.sh_tx     = r.hold;
                    n.hold_full = 1'b0;
                    n.tx_ready  = 1'b1;
                end
            end else if (srise) begin
                n.sh_rx = {r.sh_rx[6:0], sdi_s};
                n.bits  = r.bits + 5'h01;
                if (r.bits == 5'h00) begin
                    n.discard = r.rx_ready;
                    if (r.rx_ready) begin
                        n.ov = 1'b1;
                        ev[SFL_ST_OV] = 1'b1;
                    end
                    if (!r.slv_loaded && !r.hold_full) begin
                        n.ur = 1'b1;
                        ev[SFL_ST_UR] = 1'b1;
                    end else if (!r.slv_loaded) begin
                        n.sh_tx      = r.hold;
                        n.hold_full  = 1'b0;
                        n.tx_ready   = 1'b1;
                        n.slv_loaded = 1'b1;
                    end
                end
            end else if (sfall && r.bits != 5'h00) begin
                n.sh_tx = {r.sh_tx[6:0], 1'b0};
                if (r.bits == 5'h08) begin
                    n.bits       = 5'h00;
                    n.slv_loaded = r.hold_full;
                    if (!r.discard) begin
                        n.rx_buf   = r.sh_rx;
                        n.rx_ready = 1'b1;
                    end
                    if (r.hold_full) begin
                        n.sh_tx     = r.hold;
                        n.hold_full = 1'b0;
                        n.tx_ready  = 1'b1;
                    end
                end
            end
        end
        if (slv && !sel_in_act && r.force_end) begin
            n.force_end = 1'b0;
        end

        // Select edges in either mode
        cur_sel    = r.master ? r.m_sel : (r.en && sel_in_act);
        n.sel_prev = cur_sel;
        if (cur_sel && !r.sel_prev) begin
            n.select_asserted_flag = 1'b1;
            ev[SFL_ST_SSA] = 1'b1;
        end
        if (!cur_sel && r.sel_prev) begin
            n.select_released_flag = 1'b1;
            ev[SFL_ST_SSD] = 1'b1;
        end
        ev[SFL_ST_RX_READY_FLAG] = n.rx_ready && !r.rx_ready;
        ev[SFL_ST_TX_READY_FLAG] = n.tx_ready && !r.tx_ready;

        // Interrupt status, set wins over clear
        n.int_stat = n.int_stat | ev;
        n.irq      = |(n.int_stat & n.int_en);

        // Pin drive
        n.sck_oe_r  = r.en && r.master;
        n.ssel_oe_r = r.en && r.master;
        n.ssel_r    = r.spol ? n.m_sel : !n.m_sel;
        n.sdo_r     = n.sh_tx[7];
        n.sdo_oe_r  = r.en && (r.master ? n.m_sel : sel_in_act);
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            r           <= '0;
            r.st        <= ST_IDLE;
            r.tx_ready  <= SFL_STAT_RST[SFL_ST_TX_READY_FLAG];
            r.ssel_r    <= 1'b1;
        end else begin
            r <= n;
        end
    end

    assign prdata   = r.prdata;
    assign pready   = r.pready;
    assign pslverr  = r.pslverr;
    assign irq      = r.irq;
    assign sck_out  = r.sck_r;
    assign sck_oe   = r.sck_oe_r;
    assign ssel_out = r.ssel_r;
    assign ssel_oe  = r.ssel_oe_r;
    assign sdo      = r.sdo_r;
    assign sdo_oe   = r.sdo_oe_r;
endmodule

/* File: verif/sfl_monitor.sv */
// Concurrent checks on the SPI flag logic, bound into sfl_top.
// Assumes select active low, zero transfer gap, one ref_clk domain.
`timescale 1ns/10ps
module sfl_monitor #(
    parameter logic [7:0] SCK_HALF = sfl_pkg::SFL_SCK_HALF
) (
    input wire logic        ref_clk,
    input wire logic        rst_n,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        sck_out,
    input wire logic        ssel_out,
    input wire logic        ssel_oe
);
    import sfl_pkg::*;
    logic       acc;
    logic       stat_rd;
    logic       stat_wr;
    logic       rx_rd;
    logic [7:0] hi_cnt;
    logic [7:0] ssa_age;
    logic [7:0] ssd_age;
    assign acc     = psel && penable && pready;
    assign stat_rd = acc && !pwrite && paddr == SFL_STAT_ADDR;
    assign stat_wr = acc && pwrite && paddr == SFL_STAT_ADDR;
    assign rx_rd   = acc && !pwrite && paddr == SFL_RECEIVE_DATA_REGISTER_ADDR;
    // Select high time and age of select edges not yet cleared
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            hi_cnt  <= 8'h00;
            ssa_age <= 8'h00;
            ssd_age <= 8'h00;
        end else begin
            hi_cnt  <= !ssel_out ? 8'h00 : hi_cnt + {7'h0, hi_cnt != 8'hFF};
            ssa_age <= (ssel_oe && $fell(ssel_out)) ? 8'h01 : (stat_wr && pwdata[4]) ? 8'h00
                     : ssa_age + {7'h0, ssa_age != 8'h00 && ssa_age != 8'hFF};
            ssd_age <= (ssel_oe && $rose(ssel_out)) ? 8'h01 : (stat_wr && pwdata[5]) ? 8'h00
                     : ssd_age + {7'h0, ssd_age != 8'h00 && ssd_age != 8'hFF};
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    sel_gap_a: assert property (
        ssel_oe && $fell(ssel_out) |-> hi_cnt >= {SCK_HALF[6:0], 1'b0})
        else $error("select off time too short");
    ssa_seen_a: assert property (
        stat_rd && ssa_age > 8'h04 |-> prdata[SFL_ST_SSA]) else $error("assert flag missing");
    ssd_seen_a: assert property (
        stat_rd && ssd_age > 8'h04 |-> prdata[SFL_ST_SSD]) else $error("release flag missing");
    rx_clear_a: assert property (
        rx_rd ##3 stat_rd |-> !prdata[SFL_ST_RX_READY_FLAG]) else $error("rx ready not cleared");
    w1c_clear_a: assert property (
        (stat_wr && pwdata[SFL_ST_SSD] && ssel_oe && ssel_out) ##3 (stat_rd && ssel_out)
        |-> !prdata[SFL_ST_SSD]) else $error("release flag not cleared");
    stall_idle_a: assert property (
        stat_rd && ssel_oe && ssel_out && $past(ssel_out) |-> !prdata[SFL_ST_STALL])
        else $error("stalled while deselected");
    midle_busy_a: assert property (
        stat_rd && $past(sck_out) |-> !prdata[SFL_ST_MIDLE]) else $error("idle while shifting");
    force_end_a: assert property (
        stat_wr && pwdata[SFL_ST_FEND] && ssel_oe && !ssel_out |-> ##[1:400] ssel_out)
        else $error("forced end did not release select");
    fend_c: cover property (stat_wr && pwdata[SFL_ST_FEND]);
    stall_c: cover property (stat_rd && prdata[SFL_ST_STALL]);
    gap_c: cover property (ssel_oe && $fell(ssel_out));
endmodule

bind sfl_top sfl_monitor #(.SCK_HALF(SCK_HALF)) i_mon (.ref_clk, .rst_n, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .sck_out, .ssel_out, .ssel_oe);

/* File: verif/sfl_peer.sv */
// External SPI master model driving the slave-side pins.
// Assumes mode 0, msb first, select active low, 200 ns link clock.
`timescale 1ns/10ps
module sfl_peer (
    input  wire logic       miso,
    output logic            sck,
    output logic            ssel_n,
    output logic            mosi,
    output logic      [7:0] got
);
    initial begin
        sck    = 1'b0;
        ssel_n = 1'b1;
        mosi   = 1'b1;
        got    = 8'h00;
    end
    // One framed character; clock stands still outside frames
    task automatic send_byte(input logic [7:0] b);
        #7 ssel_n = 1'b0;
        #100;
        for (int i = 7; i >= 0; i--) begin
            mosi = b[i];
            #100 sck = 1'b1;
            got = {got[6:0], miso};
            #100 sck = 1'b0;
        end
        #100 ssel_n = 1'b1;
        mosi = ~mosi;
        #300;
    endtask
endmodule

/* File: verif/tb_top.sv */
// Self-checking bench for the SPI flag logic over APB.
// Assumes sfl_monitor is bound in and sfl_peer models the external master.
`timescale 1ns/10ps
module tb_top;
    import sfl_pkg::*;
    logic        ref_clk;
    logic        rst_n;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        irq;
    logic        sck_out;
    logic        sck_oe;
    logic        ssel_out;
    logic        ssel_oe;
    logic        p_sck;
    logic        p_ssel_n;
    logic        p_mosi;
    logic [7:0]  p_got;
    logic        sdo;
    logic        sdo_oe;
    logic [31:0] rd;
    logic        err;
    int          fail_count;
    int          num_checks;
    wire         sck_w  = sck_oe ? sck_out : p_sck;
    wire         ssel_w = ssel_oe ? ssel_out : p_ssel_n;
    wire         miso_w = sdo_oe ? sdo : 1'b0;

    sfl_top #(.SCK_HALF(8'h02)) i_dut (.ref_clk, .rst_n, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .irq, .sck_in(sck_w), .sck_out, .sck_oe,
        .ssel_in(ssel_w), .ssel_out, .ssel_oe, .sdi(p_mosi), .sdo, .sdo_oe);
    sfl_peer i_peer (.miso(miso_w), .sck(p_sck), .ssel_n(p_ssel_n), .mosi(p_mosi),
        .got(p_got));

    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wait_sel(input logic lvl);
        int n;
        n = 0;
        while (ssel_out !== lvl && n < 3000) begin
            @(posedge ref_clk);
            n++;
        end
        chk({31'h0, ssel_out}, {31'h0, lvl});
    endtask

    task automatic poll(input int b);
        int n;
        n = 0;
        do begin
            apb(1'b0, SFL_STAT_ADDR, 32'h0);
            n++;
        end while (rd[b] !== 1'b1 && n < 200);
    endtask

    task automatic t_reset();
        apb(1'b0, SFL_STAT_ADDR, 32'h0);
        chk(rd & 32'h0000_01FF, SFL_STAT_RST);
        apb(1'b0, 32'h4005_8030, 32'h0);
        chk({31'h0, err}, 32'h1);
        chk(rd, 32'h0);
    endtask

    task automatic t_slave();
        apb(1'b1, SFL_CFG_ADDR, 32'h0000_0001);
        apb(1'b1, SFL_TRANSMIT_DATA_REGISTER_ADDR, 32'h0000_0096);
        i_peer.send_byte(8'h3C);
        chk({24'h00_0000, p_got}, 32'h0000_0096);
        i_peer.send_byte(8'hC3);
        apb(1'b0, SFL_STAT_ADDR, 32'h0);
        chk(rd & 32'h0000_01FF, 32'h0000_013F);
        apb(1'b0, SFL_RECEIVE_DATA_REGISTER_ADDR, 32'h0);
        chk(rd & 32'h0000_00FF, 32'h0000_003C);
        apb(1'b1, SFL_STAT_ADDR, 32'h0);
        apb(1'b0, SFL_STAT_ADDR, 32'h0);
        chk(rd & 32'h0000_01FF, 32'h0000_013E);
        apb(1'b1, SFL_STAT_ADDR, 32'h0000_017F);
        apb(1'b0, SFL_STAT_ADDR, 32'h0);
        chk(rd & 32'h0000_01FF, 32'h0000_0102);
    endtask

    task automatic t_master();
        apb(1'b1, SFL_CFG_ADDR, 32'h0);
        apb(1'b1, SFL_CFG_ADDR, 32'h0000_0005);
        apb(1'b1, SFL_DLY_ADDR, 32'h0000_0300);
        apb(1'b1, SFL_INTCLR_ADDR, 32'h0000_003F);
        apb(1'b1, SFL_INTEN_ADDR, 32'h0000_0010);
        apb(1'b1, SFL_TXCTL_ADDR, 32'h0010_00A5);
        wait_sel(1'b0);
        repeat (6) begin
            apb(1'b0, SFL_STAT_ADDR, 32'h0);
            chk({31'h0, rd[SFL_ST_MIDLE]}, 32'h0);
        end
        wait_sel(1'b1);
        chk({31'h0, irq}, 32'h1);
        poll(SFL_ST_MIDLE);
        chk(rd & 32'h0000_01FF, 32'h0000_0133);
        apb(1'b1, SFL_INTCLR_ADDR, 32'h0000_0010);
        apb(1'b1, SFL_INTEN_ADDR, 32'h0);
        chk({31'h0, irq}, 32'h0);
        apb(1'b1, SFL_STAT_ADDR, 32'h0000_0030);
        apb(1'b0, SFL_STAT_ADDR, 32'h0);
        chk(rd & 32'h0000_01FF, 32'h0000_0103);
        apb(1'b0, SFL_RECEIVE_DATA_REGISTER_ADDR, 32'h0);
        apb(1'b0, SFL_STAT_ADDR, 32'h0);
        chk(rd & 32'h0000_01FF, 32'h0000_0102);
    endtask

    task automatic t_force();
        apb(1'b1, SFL_TXCTL_ADDR, 32'h0000_005A);
        wait_sel(1'b0);
        poll(SFL_ST_RX_READY_FLAG);
        apb(1'b0, SFL_RECEIVE_DATA_REGISTER_ADDR, 32'h0);
        poll(SFL_ST_STALL);
        chk({31'h0, rd[SFL_ST_STALL]}, 32'h1);
        chk({31'h0, ssel_out}, 32'h0);
        apb(1'b1, SFL_STAT_ADDR, 32'h0000_0080);
        wait_sel(1'b1);
        poll(SFL_ST_MIDLE);
        chk(rd & 32'h0000_01FF, 32'h0000_0132);
        chk({31'h0, irq}, 32'h0);
    endtask

    task automatic tally_and_finish();
        if (fail_count == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        fail_count = 0;
        num_checks = 0;
        rst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 32'h0;
        pwdata = 32'h0;
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        t_reset();
        t_slave();
        t_master();
        t_force();
        tally_and_finish();
    end

    initial begin
        #400us;
        fail_count++;
        $display("mismatch at %0t: watchdog expired", $time);
        tally_and_finish();
    end
endmodule
